/* can_transceiver_control.sv */
// Digital control core of a high-speed CAN transceiver
//
// Overview of operation
// RULE_01: Transmit low drives bus dominant; dominant bus reads low on receive.
// RULE_02: Transmit high leaves bus recessive; recessive bus reads high.
// RULE_03: Dominant timeout supervision runs only in normal mode.
// RULE_04: Every falling edge of transmit starts the timeout measurement.
// RULE_05: Timeout expiry without rising edge disables the driver.
// RULE_06: Transmit returning high clears the fault and re-enables driver.
// RULE_07: During timeout fault the receive output keeps following the bus.
// RULE_08: Controller holds transmit dominant no longer than eleven bit times; the model's hold_dom input keeps it dominant without limit.
// RULE_09: Thermal shutdown turns off driver and blocks transmit path.
// RULE_10: Thermal blocking clears by itself when over-temperature goes away.
// RULE_11: Receive path stays working during thermal shutdown.
// RULE_12: Receive output stays undriven until I/O supply is present.
// RULE_13: Standby select may be tied low for normal-only systems.
// RULE_14: Standby presents a weak-to-ground third bus condition.
// RULE_15: Standby select high gives standby, driver off; low gives normal.
// RULE_16: In standby receive stays high until a wake pattern is seen.
// RULE_17: Mode changes complete within 45 microseconds of select change; the code counts 2250 cycles after a two-flop sync.
// RULE_18: Timeout period is a tunable count of local timebase ticks.
`timescale 1ns/1ps
module can_transceiver_control #(
    parameter int LW = can_pkg::LIMIT_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Controller pins
    input wire logic txd_in,
    input wire logic standby_select,
    output logic rxd_out,
    output logic rxd_oe,
    // Analog front end
    input wire logic bus_dominant,
    input wire logic wake_pattern,
    input wire logic thermal_shutdown,
    input wire logic io_supply,
    output logic drv_enable,
    output logic drv_dominant,
    output logic bias_weak_gnd,
    // Register port
    input wire logic [can_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Types and helpers

    typedef struct packed {
        can_pkg::mode_t mode;
        logic [can_pkg::SETTLE_W-1:0] settle;
        logic [can_pkg::PRESC_W-1:0] presc;
        logic tick;
        logic wake_prev;
        logic wake_seen;
        logic tsd_prev;
        logic dto_prev;
        logic [can_pkg::IRQ_N-1:0] irq_status;
        logic [can_pkg::IRQ_N-1:0] irq_enable;
        logic [LW-1:0] dto_limit;
        logic [31:0] rdata;
        logic rxd;
        logic drv_en;
        logic drv_dom;
        logic bias_gnd;
    } core_t;

    function automatic logic hit(
        input logic [can_pkg::ADDR_W-1:0] addr,
        input logic [can_pkg::ADDR_W-1:0] offset
    );
        hit = (addr == offset);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [can_pkg::PIN_N-1:0] pins_raw;
    logic [can_pkg::PIN_N-1:0] pins_s;
    logic txd_s;
    logic stb_s;
    logic bus_s;
    logic wake_s;
    logic tsd_s;
    logic io_s;

    assign pins_raw[can_pkg::PIN_TXD] = txd_in;
    assign pins_raw[can_pkg::PIN_STB] = standby_select;
    assign pins_raw[can_pkg::PIN_BUS] = bus_dominant;
    assign pins_raw[can_pkg::PIN_WAKE] = wake_pattern;
    assign pins_raw[can_pkg::PIN_TSD] = thermal_shutdown;
    assign pins_raw[can_pkg::PIN_IO] = io_supply;

    pin_sync #(
        .W(can_pkg::PIN_N),
        .RST_VAL(can_pkg::PIN_RST)
    ) u_pin_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign txd_s = pins_s[can_pkg::PIN_TXD];
    assign stb_s = pins_s[can_pkg::PIN_STB];
    assign bus_s = pins_s[can_pkg::PIN_BUS];
    assign wake_s = pins_s[can_pkg::PIN_WAKE];
    assign tsd_s = pins_s[can_pkg::PIN_TSD];
    assign io_s = pins_s[can_pkg::PIN_IO];

    ////////////////////////////////////////////////////////////////////////
    // Dominant timeout

    core_t cq;
    core_t cd;
    logic normal;
    logic dto_fault;
    logic [LW-1:0] dto_count;

    assign normal = (cq.mode == can_pkg::MODE_NORMAL);

    dominant_timeout #(
        .LW(LW)
    ) u_dominant_timeout (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .active(normal), // [RULE_03]
        .tick(cq.tick),
        .limit(cq.dto_limit), // [RULE_18]
        .txd(txd_s),
        .fault(dto_fault),
        .count(dto_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Core state

    logic mode_done;
    logic wake_edge;
    logic [can_pkg::IRQ_N-1:0] events;
    logic [can_pkg::IRQ_N-1:0] clear_bits;
    logic [can_pkg::STAT_W-1:0] status;
    logic [31:0] read_word;
    logic settle_end;

    always_comb begin
        cd = cq;
        mode_done = 1'b0;
        settle_end = (cq.settle == can_pkg::SETTLE_LAST);

        // Microsecond timebase for the timeout counter
        if (cq.presc == can_pkg::PRESC_LAST) begin
            cd.presc = '0;
            cd.tick = 1'b1; // [RULE_18]
        end else begin
            cd.presc = cq.presc + can_pkg::PRESC_W'(1);
            cd.tick = 1'b0;
        end

        // A reversal mid-change restarts the settle count, so each
        // direction still finishes within the mode change time.
        unique case (cq.mode)
            can_pkg::MODE_NORMAL: begin
                if (stb_s) begin
                    cd.mode = can_pkg::MODE_TO_STANDBY; // [RULE_15]
                    cd.settle = '0;
                end
            end
            can_pkg::MODE_TO_STANDBY: begin
                if (!stb_s) begin
                    cd.mode = can_pkg::MODE_TO_NORMAL;
                    cd.settle = '0;
                end else if (settle_end) begin
                    cd.mode = can_pkg::MODE_STANDBY; // [RULE_17]
                    mode_done = 1'b1;
                end else begin
                    cd.settle = cq.settle + can_pkg::SETTLE_W'(1);
                end
            end
            can_pkg::MODE_STANDBY: begin
                if (!stb_s) begin
                    cd.mode = can_pkg::MODE_TO_NORMAL; // [RULE_15]
                    cd.settle = '0;
                end
            end
            can_pkg::MODE_TO_NORMAL: begin
                if (stb_s) begin
                    cd.mode = can_pkg::MODE_TO_STANDBY;
                    cd.settle = '0;
                end else if (settle_end) begin
                    cd.mode = can_pkg::MODE_NORMAL; // [RULE_17]
                    mode_done = 1'b1;
                end else begin
                    cd.settle = cq.settle + can_pkg::SETTLE_W'(1);
                end
            end
            default: begin
                cd.mode = can_pkg::MODE_STANDBY;
                cd.settle = '0;
            end
        endcase

        // Wake detection only counts while fully in standby
        cd.wake_prev = wake_s;
        wake_edge = wake_s && !cq.wake_prev &&
            (cq.mode == can_pkg::MODE_STANDBY);
        if (normal) begin
            cd.wake_seen = 1'b0;
        end else if (wake_edge) begin
            cd.wake_seen = 1'b1; // [RULE_16]
        end

        // Receive output; timeout and thermal faults never gate it
        if (cq.mode == can_pkg::MODE_NORMAL ||
            cq.mode == can_pkg::MODE_TO_STANDBY) begin
            cd.rxd = !bus_s; // [RULE_01] [RULE_02] [RULE_07] [RULE_11]
        end else if (cq.wake_seen) begin
            cd.rxd = !bus_s;
        end else begin
            cd.rxd = 1'b1; // [RULE_16]
        end

        // Driver: normal mode only, off on timeout or over-temperature
        cd.drv_en = normal && !dto_fault && !tsd_s; // [RULE_05] [RULE_09]
        cd.drv_dom = normal && !dto_fault && !tsd_s && !txd_s; // [RULE_01]
        cd.bias_gnd = (cq.mode == can_pkg::MODE_STANDBY); // [RULE_14]
        // Thermal blocking follows the live level, no latch
        cd.tsd_prev = tsd_s; // [RULE_10]
        cd.dto_prev = dto_fault;

        // Sticky events; a new event wins over a same-cycle clear
        events = '0;
        events[can_pkg::IRQ_DTO] = dto_fault && !cq.dto_prev;
        events[can_pkg::IRQ_TSD] = tsd_s && !cq.tsd_prev;
        events[can_pkg::IRQ_WAKE] = wake_edge;
        events[can_pkg::IRQ_MODE] = mode_done;
        clear_bits = '0;
        if (reg_wr && hit(reg_addr, can_pkg::ADDR_IRQ_CLEAR)) begin
            clear_bits = reg_wdata[can_pkg::IRQ_N-1:0];
        end
        cd.irq_status = (cq.irq_status & ~clear_bits) | events;

        // Register writes
        if (reg_wr && hit(reg_addr, can_pkg::ADDR_IRQ_ENABLE)) begin
            cd.irq_enable = reg_wdata[can_pkg::IRQ_N-1:0];
        end
        if (reg_wr && hit(reg_addr, can_pkg::ADDR_DTO_LIMIT)) begin
            cd.dto_limit = reg_wdata[LW-1:0]; // [RULE_18]
        end

        // Register reads; data only in the cycle after the strobe
        status = '0;
        status[can_pkg::STAT_NORMAL] = normal;
        status[can_pkg::STAT_STANDBY] = (cq.mode == can_pkg::MODE_STANDBY);
        status[can_pkg::STAT_DTO] = dto_fault;
        status[can_pkg::STAT_TSD] = tsd_s;
        status[can_pkg::STAT_WAKE] = cq.wake_seen;
        status[can_pkg::STAT_IO] = io_s;
        status[can_pkg::STAT_TXD] = txd_s;
        status[can_pkg::STAT_BUS] = bus_s;
        read_word = '0;
        if (hit(reg_addr, can_pkg::ADDR_STATUS)) begin
            read_word[can_pkg::STAT_W-1:0] = status;
        end else if (hit(reg_addr, can_pkg::ADDR_IRQ_STATUS)) begin
            read_word[can_pkg::IRQ_N-1:0] = cq.irq_status;
        end else if (hit(reg_addr, can_pkg::ADDR_IRQ_ENABLE)) begin
            read_word[can_pkg::IRQ_N-1:0] = cq.irq_enable;
        end else if (hit(reg_addr, can_pkg::ADDR_DTO_LIMIT)) begin
            read_word[LW-1:0] = cq.dto_limit;
        end else if (hit(reg_addr, can_pkg::ADDR_DTO_COUNT)) begin
            read_word[LW-1:0] = dto_count;
        end
        cd.rdata = reg_rd ? read_word : 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cq <= '{
                mode: can_pkg::MODE_STANDBY,
                settle: '0,
                presc: '0,
                tick: 1'b0,
                wake_prev: 1'b0,
                wake_seen: 1'b0,
                tsd_prev: 1'b0,
                dto_prev: 1'b0,
                irq_status: '0,
                irq_enable: can_pkg::IRQ_ENABLE_RST,
                dto_limit: can_pkg::DTO_LIMIT_RST,
                rdata: 32'h0000_0000,
                rxd: 1'b1,
                drv_en: 1'b0,
                drv_dom: 1'b0,
                bias_gnd: 1'b0
            };
        end else begin
            cq <= cd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rxd_out = cq.rxd;
    // Floats the receive pin until the I/O rail is up
    assign rxd_oe = io_s; // [RULE_12]
    assign drv_enable = cq.drv_en;
    assign drv_dominant = cq.drv_dom;
    assign bias_weak_gnd = cq.bias_gnd;
    assign reg_rdata = cq.rdata;
    assign irq = |(cq.irq_status & cq.irq_enable);

endmodule : can_transceiver_control

/* can_pkg.sv */
// Shared constants and types for the CAN transceiver control block
package can_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int MODE_TIME_US = 45;
    // Longest time: round down to whole cycles
    localparam int MODE_CYCLES = MODE_TIME_US * CLK_MHZ;
    localparam int SETTLE_W = 12;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(MODE_CYCLES - 1);
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int PRESC_W = 6;
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);
    localparam int DOMINANT_TIMEOUT_PERIOD_US = 4000;
    localparam int LIMIT_W = 16;
    localparam logic [LIMIT_W-1:0] DTO_LIMIT_RST =
        LIMIT_W'(DOMINANT_TIMEOUT_PERIOD_US / TICK_US);

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_DTO_LIMIT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_DTO_COUNT = 8'h14;

    // Live status bits
    localparam int STAT_NORMAL = 0;
    localparam int STAT_STANDBY = 1;
    localparam int STAT_DTO = 2;
    localparam int STAT_TSD = 3;
    localparam int STAT_WAKE = 4;
    localparam int STAT_IO = 5;
    localparam int STAT_TXD = 6;
    localparam int STAT_BUS = 7;
    localparam int STAT_W = 8;

    // Interrupt bits
    localparam int IRQ_DTO = 0;
    localparam int IRQ_TSD = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_MODE = 3;
    localparam int IRQ_N = 4;
    localparam logic [IRQ_N-1:0] IRQ_ENABLE_RST = 4'h0;

    // Synchronised pin positions
    localparam int PIN_TXD = 0;
    localparam int PIN_STB = 1;
    localparam int PIN_BUS = 2;
    localparam int PIN_WAKE = 3;
    localparam int PIN_TSD = 4;
    localparam int PIN_IO = 5;
    localparam int PIN_N = 6;
    // Idle pin levels: transmit recessive, standby selected
    localparam logic [PIN_N-1:0] PIN_RST = 6'h03;

    ////////////////////////////////////////////////////////////////////////
    // Operating mode
    typedef enum logic [3:0] {
        MODE_NORMAL = 4'h1,
        MODE_TO_STANDBY = 4'h2,
        MODE_STANDBY = 4'h4,
        MODE_TO_NORMAL = 4'h8
    } mode_t;

endpackage : can_pkg

/* pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_t;

    sync_t sq;
    sync_t sd;

    always_comb begin
        sd = sq;
        sd.meta = din;
        // First stage feeds only the second stage
        sd.stable = sq.meta;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sq <= {RST_VAL, RST_VAL};
        end else begin
            sq <= sd;
        end
    end

    assign dout = sq.stable;

endmodule : pin_sync

/* dominant_timeout.sv */
// Transmit-dominant timeout supervisor on a microsecond timebase
`timescale 1ns/1ps
module dominant_timeout #(
    parameter int LW = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic active,
    input wire logic tick,
    input wire logic [LW-1:0] limit,
    input wire logic txd,
    // Result
    output logic fault,
    output logic [LW-1:0] count
);

    typedef struct packed {
        logic txd_prev;
        logic armed;
        logic fault;
        logic [LW-1:0] count;
    } dto_t;

    dto_t tq;
    dto_t td;
    logic [LW-1:0] count_inc;

    always_comb begin
        td = tq;
        count_inc = tq.count + LW'(1);
        td.txd_prev = txd;
        if (!active) begin
            // Driver never on outside normal mode
            td.armed = 1'b0; // [RULE_03]
            td.fault = 1'b0;
            td.count = '0;
        end else if (txd) begin
            // Recessive level releases the fault
            td.armed = 1'b0; // [RULE_06]
            td.fault = 1'b0; // [RULE_06]
            td.count = '0;
        end else if (tq.txd_prev) begin
            // Falling edge restarts the measurement
            td.armed = 1'b1; // [RULE_04]
            td.count = '0; // [RULE_04]
        end else if (tq.armed && !tq.fault && tick) begin
            td.count = count_inc; // [RULE_18]
            if (count_inc >= limit) begin
                td.fault = 1'b1; // [RULE_05]
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tq <= '{txd_prev: 1'b1, armed: 1'b0, fault: 1'b0, count: '0};
        end else begin
            tq <= td;
        end
    end

    assign fault = tq.fault;
    assign count = tq.count;

endmodule : dominant_timeout

/* can_transceiver_control_monitor.sv */
// Port checker for the CAN transceiver control block
`timescale 1ns/1ps
module can_transceiver_control_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pins
    input wire logic standby_select,
    input wire logic txd_in,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    input wire logic bus_dominant,
    input wire logic wake_pattern,
    input wire logic thermal_shutdown,
    input wire logic io_supply,
    input wire logic drv_enable,
    input wire logic drv_dominant,
    input wire logic bias_weak_gnd,
    // Register port
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    // Sync and output flops on top of settle
    localparam logic [11:0] LIM = 12'(can_pkg::MODE_CYCLES + 4);
    logic [11:0] hi_q;
    logic [11:0] lo_q;
    logic woke_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hi_q <= 12'h0;
            lo_q <= 12'h0;
            woke_q <= 1'b0;
        end else begin
            hi_q <= !standby_select ? 12'h0 : hi_q + 12'(hi_q != LIM);
            lo_q <= standby_select ? 12'h0 : lo_q + 12'(lo_q != LIM);
            woke_q <= !drv_enable && (woke_q || wake_pattern);
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_hot;
        thermal_shutdown [*4];
    endsequence
    sequence s_no_io;
        !io_supply [*4];
    endsequence
    property p_dom_en;
        drv_dominant |-> drv_enable;
    endproperty
    property p_tx_map;
        drv_enable |-> drv_dominant == !$past(txd_in, 3);
    endproperty
    property p_rx_map;
        drv_enable |-> rxd_out == !$past(bus_dominant, 3);
    endproperty
    property p_bias;
        bias_weak_gnd |-> !drv_enable && !drv_dominant;
    endproperty
    property p_hot;
        s_hot |-> !drv_enable;
    endproperty
    property p_no_io;
        s_no_io |-> !rxd_oe;
    endproperty
    property p_stby_rxd;
        bias_weak_gnd && $past(bias_weak_gnd) && !woke_q |-> rxd_out;
    endproperty
    property p_to_stby;
        hi_q == LIM |-> bias_weak_gnd && !drv_enable;
    endproperty
    property p_to_norm;
        lo_q == LIM |-> !bias_weak_gnd;
    endproperty
    property p_rdata;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_dom_en: assert property (p_dom_en)
        else $error("dom without en");
    a_tx_map: assert property (p_tx_map)
        else $error("tx map");
    a_rx_map: assert property (p_rx_map)
        else $error("rx map");
    a_bias: assert property (p_bias)
        else $error("bias drive");
    a_hot: assert property (p_hot)
        else $error("hot drive");
    a_no_io: assert property (p_no_io)
        else $error("rx no io");
    a_stby_rxd: assert property (p_stby_rxd)
        else $error("standby rx");
    a_to_stby: assert property (p_to_stby)
        else $error("standby late");
    a_to_norm: assert property (p_to_norm)
        else $error("normal late");
    a_rdata: assert property (p_rdata)
        else $error("stray rdata");
endmodule : can_transceiver_control_monitor

bind can_transceiver_control can_transceiver_control_monitor
    can_transceiver_control_monitor_i (.*);

/* can_ctrl_model.sv */
// Protocol controller model driving transmit and standby pins
`timescale 1ns/1ps
module can_ctrl_model #(
    parameter int BIT = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Requests from the bench
    input wire logic go,
    input wire logic [3:0] dom_bits,
    input wire logic hold_dom,
    input wire logic stb_req,
    // Pins toward the transceiver, busy back to the bench
    output logic txd_in,
    output logic standby_select,
    output logic busy
);
    logic [7:0] left_q;
    logic [3:0] bits;
    logic start;
    // Eleven dominant bits is the protocol worst case
    assign bits = (dom_bits > 4'hB) ? 4'hB : dom_bits;
    assign busy = (left_q != 8'h00);
    assign start = go && !busy;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            left_q <= 8'h00;
            txd_in <= 1'b1;
            standby_select <= 1'b1;
        end else begin
            standby_select <= stb_req;
            if (start) begin
                left_q <= 8'(bits) * 8'(BIT);
            end else if (busy) begin
                left_q <= left_q - 8'h01;
            end
            // Low is dominant
            txd_in <= !(hold_dom || (start && bits != 4'h0) ||
                left_q > 8'h01);
        end
    end
endmodule : can_ctrl_model

/* can_transceiver_control_test.sv */
// Self-checking bench for the CAN transceiver control block
`timescale 1ns/1ps
module can_transceiver_control_test;
    logic mclk, sys_rst, txd_in, standby_select, rxd_out, rxd_oe;
    logic bus_dominant, wake_pattern, thermal_shutdown, io_supply;
    logic drv_enable, drv_dominant, bias_weak_gnd, reg_wr, reg_rd, irq;
    logic stb_req, hold_dom, go, other_dom, busy;
    logic [3:0] dom_bits;
    logic [can_pkg::ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    int failures = 0;
    int comparisons = 0;
    localparam int MC = can_pkg::MODE_CYCLES;
    // Other nodes may pull dominant
    assign bus_dominant = (drv_enable & drv_dominant) | other_dom;

    can_transceiver_control can_transceiver_control_i (.mclk(mclk),
        .sys_rst(sys_rst), .txd_in(txd_in),
        .standby_select(standby_select), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .bus_dominant(bus_dominant),
        .wake_pattern(wake_pattern), .thermal_shutdown(thermal_shutdown),
        .io_supply(io_supply), .drv_enable(drv_enable),
        .drv_dominant(drv_dominant), .bias_weak_gnd(bias_weak_gnd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    can_ctrl_model can_ctrl_model_i (.*);
    ////////////////////////////////////////
    function automatic logic exp_rx(input logic own, input logic oth);
        return !(own | oth);
    endfunction : exp_rx
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
        input string m);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
        input string m);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e, m);
    endtask : rdchk
    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        complete_run();
    end
    initial begin
        sys_rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {wake_pattern, thermal_shutdown, io_supply} = '0;
        {hold_dom, go, dom_bits, other_dom} = '0;
        stb_req = 1'b1;
        rv = $urandom(95);
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rdchk(can_pkg::ADDR_IRQ_ENABLE, 32'(can_pkg::IRQ_ENABLE_RST), "en");
        rdchk(can_pkg::ADDR_DTO_LIMIT, 32'(can_pkg::DTO_LIMIT_RST),
            "lim");
        wr(8'h20, 32'hFFFF_FFFF);
        rdchk(8'h20, 32'h0, "unmap");
        rdchk(can_pkg::ADDR_IRQ_CLEAR, 32'h0, "clr");
        chk(rxd_oe, 0, "oe lo");
        $display("reset done");
        @(posedge mclk);
        io_supply <= 1'b1;
        other_dom <= 1'b1;
        step(5);
        chk(rxd_oe, 1, "oe hi");
        chk(rxd_out, 1, "sb rx");
        chk(bias_weak_gnd, 1, "bias");
        chk(drv_enable, 0, "sb drv");
        wr(can_pkg::ADDR_IRQ_ENABLE, 32'h4);
        @(posedge mclk);
        wake_pattern <= 1'b1;
        @(posedge mclk);
        wake_pattern <= 1'b0;
        step(5);
        chk(rxd_out, 0, "wake rx");
        chk(irq, 1, "wake");
        wr(can_pkg::ADDR_IRQ_ENABLE, 32'h0);
        step(1);
        chk(irq, 0, "mask");
        wr(can_pkg::ADDR_IRQ_CLEAR, 32'hF);
        rdchk(can_pkg::ADDR_IRQ_STATUS, 32'h0, "clr st");
        $display("standby done");
        @(posedge mclk);
        stb_req <= 1'b0;
        other_dom <= 1'b0;
        step(MC + 8);
        chk(drv_enable, 1, "nrm drv");
        chk(bias_weak_gnd, 0, "nrm bias");
        rdchk(can_pkg::ADDR_IRQ_STATUS, 32'h8, "mode");
        rdchk(can_pkg::ADDR_STATUS, 32'h61, "stat");
        $display("normal done");
        // Corner frames first: capped length, then empty
        for (int i = 0; i < 30; i++) begin
            @(posedge mclk);
            other_dom <= 1'($urandom_range(0, 1));
            dom_bits <= (i == 0) ? 4'hF : (i == 1) ? 4'h0
                : 4'($urandom_range(0, 15));
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            step(3);
            chk(drv_dominant, dom_bits != 4'h0, "tx dom");
            chk(rxd_out, exp_rx(1'b0, other_dom), "rx");
            for (int k = 0; k < 100 && busy !== 1'b0; k++) step(1);
            step(6);
            chk(drv_dominant, 0, "tx rec");
            chk(rxd_out, exp_rx(1'b0, other_dom), "rx rec");
        end
        $display("traffic done");
        wr(can_pkg::ADDR_DTO_LIMIT, 32'h3);
        rdchk(can_pkg::ADDR_DTO_LIMIT, 32'h3, "lim rw");
        @(posedge mclk);
        hold_dom <= 1'b1;
        other_dom <= 1'b0;
        step(100);
        @(posedge mclk);
        hold_dom <= 1'b0;
        step(2);
        @(posedge mclk);
        hold_dom <= 1'b1;
        step(100);
        chk(drv_enable, 1, "restart");
        step(110);
        chk(drv_enable, 0, "dto");
        @(posedge mclk);
        other_dom <= 1'b1;
        step(5);
        chk(rxd_out, 0, "dto rx");
        @(posedge mclk);
        other_dom <= 1'b0;
        hold_dom <= 1'b0;
        step(6);
        chk(rxd_out, 1, "rx after");
        chk(drv_enable, 1, "reenable");
        rdchk(can_pkg::ADDR_IRQ_STATUS, 32'h9, "dto st");
        wr(can_pkg::ADDR_IRQ_CLEAR, 32'hF);
        $display("timeout done");
        @(posedge mclk);
        hold_dom <= 1'b1;
        thermal_shutdown <= 1'b1;
        other_dom <= 1'b1;
        step(5);
        chk(drv_enable, 0, "hot drv");
        chk(rxd_out, 0, "hot rx");
        @(posedge mclk);
        thermal_shutdown <= 1'b0;
        other_dom <= 1'b0;
        step(5);
        chk(drv_dominant, 1, "cool");
        @(posedge mclk);
        hold_dom <= 1'b0;
        rdchk(can_pkg::ADDR_IRQ_STATUS, 32'h2, "hot st");
        wr(can_pkg::ADDR_IRQ_CLEAR, 32'hF);
        $display("thermal done");
        @(posedge mclk);
        stb_req <= 1'b1;
        step(MC + 8);
        chk(bias_weak_gnd, 1, "sb bias");
        @(posedge mclk);
        hold_dom <= 1'b1;
        step(300);
        rdchk(can_pkg::ADDR_IRQ_STATUS, 32'h8, "sb dto");
        $display("back to standby done");
        complete_run();
    end
endmodule : can_transceiver_control_test
